/* gpib_remote_local_srq_tb.sv */
// bench: controller end commands the instrument end over the bus
`timescale 1ns/10ps
`include "grls_defs.svh"
module gpib_remote_local_srq_tb;
  logic core_clk, rst, p_awr, p_twr, p_if, p_iwr, k_loc, k_out, out_on;
  logic [4:0] p_addr, bus_addr;
  logic [1:0] p_term, term_sel;
  logic [7:0] k_oth, oth_ok, d_rxd, d_txd, sre, stb, c_txd, c_rxd;
  logic [7:0] cond, evt_en, evt;
  logic [8:0] last_rx;
  logic lamp, lockout, if_gpib, loc_ok, out_ok, d_rxe, d_rxv, d_last;
  logic d_txv, d_txr, evt_clr, osb, esb, exs, mav, dclr, dtrg;
  logic c_ren, c_atn, c_txv, c_txr, c_rxen, c_rxe, c_rxv, srq;
  int mismatches, comparisons, n_clr, n_trg;

  grls_bus_if bus();
  grls_dev i_grls_dev (.core_clk(core_clk), .rst(rst), .bus(bus),
    .panel_addr(p_addr), .panel_addr_wr(p_awr), .panel_term(p_term),
    .panel_term_wr(p_twr), .panel_if_gpib(p_if), .panel_if_wr(p_iwr),
    .key_local(k_loc), .key_out(k_out), .key_other(k_oth),
    .output_on(out_on), .remote_indicator_lamp(lamp), .lockout(lockout),
    .if_gpib(if_gpib), .bus_addr(bus_addr), .term_sel(term_sel),
    .local_key_ok(loc_ok), .out_key_ok(out_ok), .other_key_ok(oth_ok),
    .rx_data(d_rxd), .rx_eoi(d_rxe), .rx_valid(d_rxv), .tx_data(d_txd),
    .tx_last(d_last), .tx_valid(d_txv), .tx_ready(d_txr), .cond(cond),
    .evt_en(evt_en), .evt_clr(evt_clr), .evt(evt), .sre(sre),
    .osb_sum(osb), .esb_sum(esb), .exs_sum(exs), .queue_nonempty(mav),
    .stb(stb), .dev_clear(dclr), .dev_trigger(dtrg));
  grls_ctl i_grls_ctl (.core_clk(core_clk), .rst(rst), .bus(bus),
    .ren_in(c_ren), .tx_data(c_txd), .tx_atn(c_atn), .tx_eoi(1'b0),
    .tx_valid(c_txv), .tx_ready(c_txr), .rx_en(c_rxen), .rx_data(c_rxd),
    .rx_eoi(c_rxe), .rx_valid(c_rxv), .srq(srq));
  grls_checker i_grls_checker (.core_clk(core_clk), .rst(rst),
    .dev_d_o(bus.dev_d_o), .dev_d_oe(bus.dev_d_oe),
    .dev_dav_oe(bus.dev_dav_oe), .dev_eoi_oe(bus.dev_eoi_oe),
    .dev_srq_oe(bus.dev_srq_oe), .ctl_d_o(bus.ctl_d_o),
    .ctl_dav_oe(bus.ctl_dav_oe), .nrfd(bus.nrfd), .ndac(bus.ndac),
    .atn(bus.atn), .ren(bus.ren));

  // ================================================================
  // access tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ok low: no acceptor may answer
  task automatic send(input logic [7:0] b, input logic a,
                      input logic ok = 1'b1);
    int i;
    c_txd <= b;
    c_atn <= a;
    c_txv <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (c_txr !== 1'b1 && i < 50);
    check(c_txr, ok);
    c_txv <= 1'b0;
    tk(3);
  endtask

  task automatic cmd(input logic [6:0] c);
    send({1'b0, c}, 1'b1);
  endtask

  // m low leaves the end flag out of the compare
  task automatic rd(input logic [8:0] exp, input logic m);
    int i;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (c_rxv !== 1'b1 && i < 60);
    check({c_rxv, c_rxe & m, c_rxd}, {1'b1, exp});
  endtask

  task automatic press(input logic [9:0] k, input logic [9:0] exp);
    {k_loc, k_out, k_oth} <= k;
    @(posedge core_clk);
    {k_loc, k_out, k_oth} <= 10'h000;
    @(posedge core_clk);
    check({loc_ok, out_ok, oth_ok}, exp);
  endtask

  task automatic panel(input logic [4:0] a, input logic [1:0] t,
                       input logic g, input logic [2:0] wr);
    p_addr <= a;
    p_term <= t;
    p_if <= g;
    {p_awr, p_twr, p_iwr} <= wr;
    @(posedge core_clk);
    {p_awr, p_twr, p_iwr} <= 3'h0;
    tk(1);
  endtask

  task automatic conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ================================================================
  // clock, monitors, watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (d_txr === 1'b1) d_txv <= 1'b0;
    if (d_rxv === 1'b1) last_rx <= {d_rxe, d_rxd};
    if (dclr === 1'b1) n_clr++;
    if (dtrg === 1'b1) n_trg++;
  end

  initial begin
    #1000000;
    mismatches++;
    conclude();
  end

  // ================================================================
  // scenarios
  initial begin
    {p_awr, p_twr, p_if, p_iwr, k_loc, k_out, out_on} = 7'h00;
    {p_addr, p_term, k_oth, d_txd, sre, c_txd, cond, evt_en} = 55'h0;
    {d_last, d_txv, evt_clr, osb, esb, exs, mav} = 7'h00;
    {c_ren, c_atn, c_txv, c_rxen} = 4'h0;
    {mismatches, comparisons, n_clr, n_trg} = 128'h0;
    rst = 1'b1;
    tk(2);
    rst <= 1'b0;
    tk(1);
    check({lamp, lockout, if_gpib, bus_addr, term_sel}, {2'h0, 1'b1,
      `GRLS_ADDR_DEF, `GRLS_TERM_DEF});
    out_on <= 1'b1;
    press(10'h3ff, 10'h3ff);
    c_ren <= 1'b1;
    cmd({`GRLS_LAG_BASE, 5'h02});
    check(lamp, 1'b0);
    send(8'h41, 1'b0);
    check({lamp, last_rx}, 10'h241);
    press(10'h1ff, 10'h000);
    out_on <= 1'b0;
    press(10'h100, 10'h100);
    press(10'h200, 10'h200);
    check(lamp, 1'b0);
    send(8'h42, 1'b0);
    cmd(`GRLS_CMD_LLO);
    check({lamp, lockout}, 2'h3);
    press(10'h3ff, 10'h000);
    cmd(`GRLS_CMD_GTL);
    check({lamp, lockout}, 2'h1);
    c_ren <= 1'b0;
    tk(3);
    check({lamp, lockout, bus_addr}, {2'h0, 5'h02});
    cmd(`GRLS_CMD_DCL);
    cmd(`GRLS_CMD_GET);
    check({n_clr[3:0], n_trg[3:0]}, 8'h11);
    panel(5'h1f, 2'h0, 1'b1, 3'h4);
    check(bus_addr, 5'h02);
    panel(5'h1e, 2'h0, 1'b1, 3'h4);
    check(bus_addr, `GRLS_ADDR_MAX);
    for (int t = 0; t < 3; t++) begin
      panel(5'h1e, t[1:0], 1'b1, 3'h2);
      check(term_sel, t[1:0]);
      cmd(`GRLS_CMD_UNL);
      cmd({`GRLS_TAG_BASE, 5'h1e});
      d_txd <= 8'h5a;
      d_last <= 1'b1;
      d_txv <= 1'b1;
      c_rxen <= 1'b1;
      rd(9'h05a, 1'b1);
      rd({t != 0, t == 2 ? `GRLS_CHR_LF : `GRLS_CHR_CR}, 1'b1);
      if (t == 0) rd({1'b1, `GRLS_CHR_LF}, 1'b1);
      c_rxen <= 1'b0;
      tk(4);
    end
    panel(5'h1e, 2'h3, 1'b1, 3'h2);
    check(term_sel, 2'h2);
    osb <= 1'b1;
    exs <= 1'b1;
    sre <= 8'h10;
    mav <= 1'b1;
    tk(3);
    check(srq, 1'b1);
    cmd(`GRLS_CMD_SPE);
    cmd({`GRLS_TAG_BASE, 5'h1e});
    c_rxen <= 1'b1;
    rd(9'h0d1, 1'b0);
    c_rxen <= 1'b0;
    cmd(`GRLS_CMD_SPD);
    check({srq, stb}, 9'h091);
    mav <= 1'b0;
    evt_en <= 8'h01;
    cond <= 8'h01;
    tk(2);
    check({evt, stb}, 16'h0183);
    evt_clr <= 1'b1;
    tk(1);
    evt_clr <= 1'b0;
    tk(1);
    check({evt, stb[1]}, 9'h000);
    panel(5'h1e, 2'h2, 1'b0, 3'h1);
    c_ren <= 1'b1;
    send({1'b0, `GRLS_LAG_BASE, 5'h1e}, 1'b1, 1'b0);
    send(8'h43, 1'b0, 1'b0);
    check({if_gpib, lamp}, 2'h0);
    conclude();
  end
endmodule // gpib_remote_local_srq_tb

/* grls_bus_if.sv */
// instrument bus wires with wired-or resolution, true level = 1
`timescale 1ns/10ps
interface grls_bus_if;
  logic [7:0] dev_d_o;
  logic dev_d_oe;
  logic dev_dav_oe;
  logic dev_nrfd_oe;
  logic dev_ndac_oe;
  logic dev_eoi_oe;
  logic dev_srq_oe;
  logic [7:0] ctl_d_o;
  logic ctl_d_oe;
  logic ctl_dav_oe;
  logic ctl_nrfd_oe;
  logic ctl_ndac_oe;
  logic ctl_eoi_oe;
  logic ctl_atn_oe;
  logic ctl_ren_oe;
  logic [7:0] dio;
  logic dav;
  logic nrfd;
  logic ndac;
  logic eoi;
  logic atn;
  logic ren;
  logic srq;

  // ================================================================
  // resolution
  assign dio = (dev_d_oe ? dev_d_o : 8'h00) | (ctl_d_oe ? ctl_d_o : 8'h00);
  assign dav = dev_dav_oe | ctl_dav_oe;
  assign nrfd = dev_nrfd_oe | ctl_nrfd_oe;
  assign ndac = dev_ndac_oe | ctl_ndac_oe;
  assign eoi = dev_eoi_oe | ctl_eoi_oe;
  assign atn = ctl_atn_oe;
  assign ren = ctl_ren_oe;
  assign srq = dev_srq_oe;

  modport dev (
    output dev_d_o, dev_d_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe,
    output dev_eoi_oe, dev_srq_oe,
    input dio, dav, nrfd, ndac, eoi, atn, ren
  );

  modport ctl (
    output ctl_d_o, ctl_d_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe,
    output ctl_eoi_oe, ctl_atn_oe, ctl_ren_oe,
    input dio, dav, nrfd, ndac, eoi, srq
  );
endinterface

/* grls_checker.sv */
// bus-level assertions between the instrument end and the controller end
`timescale 1ns/10ps
module grls_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] dev_d_o,
  input wire logic dev_d_oe,
  input wire logic dev_dav_oe,
  input wire logic dev_eoi_oe,
  input wire logic dev_srq_oe,
  input wire logic [7:0] ctl_d_o,
  input wire logic ctl_dav_oe,
  input wire logic nrfd,
  input wire logic ndac,
  input wire logic atn,
  input wire logic ren
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ================================================================
  // handshake and talker behaviour
  a_src_start: assert property ($rose(dev_dav_oe) |->
    !$past(nrfd) && $past(ndac)) else $error("dav raised too early");
  a_src_hold: assert property (dev_dav_oe && ndac && !atn |=>
    dev_dav_oe && $stable(dev_d_o)) else $error("talker byte moved");
  a_src_release: assert property (dev_dav_oe && !ndac |=>
    !dev_dav_oe) else $error("talker kept dav after accept");
  a_data_drive: assert property (dev_dav_oe |-> dev_d_oe)
    else $error("dav without data drive");
  a_talk_quiet: assert property (atn && $past(atn) |->
    !dev_d_oe) else $error("device drives data under atn");
  a_no_ppoll: assert property (atn && $past(atn) |->
    !dev_eoi_oe) else $error("device answers a parallel poll");
  a_ctl_hold: assert property (ctl_dav_oe && ndac |=>
    ctl_dav_oe && $stable(ctl_d_o)) else $error("controller byte moved");
  a_ctl_release: assert property (ctl_dav_oe && !ndac |=>
    !ctl_dav_oe) else $error("controller kept dav after accept");
  a_srq_poll: assert property ($fell(dev_srq_oe) |->
    $past(dev_dav_oe) && !$past(ndac)) else $error("srq dropped early");

  c_srq: cover property ($rose(dev_srq_oe));
  c_talk: cover property ($rose(dev_dav_oe));
  c_ren_drop: cover property ($fell(ren));
endmodule // grls_checker

/* grls_ctl.sv */
// controller end: sends commands and data, reads talker bytes
`timescale 1ns/10ps
`include "grls_defs.svh"
module grls_ctl (
  input wire logic core_clk,
  input wire logic rst,
  grls_bus_if.ctl bus,
  input wire logic ren_in,
  input wire logic [7:0] tx_data,
  input wire logic tx_atn,
  input wire logic tx_eoi,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic rx_en,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  output logic rx_valid,
  output logic srq
);

  typedef struct packed {
    grls_pkg::grls_hs_t hs;
    logic [7:0] dout;
    logic doe;
    logic eoi;
    logic atn;
    logic ren;
    logic [7:0] rxd;
    logic rxe;
    logic rxv;
  } grls_ctl_st_t;

  grls_ctl_st_t st_ff;
  grls_ctl_st_t nxt_st;
  logic acc_act;

  // ================================================================
  // handshakes
  assign acc_act = rx_en & ~st_ff.atn;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rxv = 1'b0;
    nxt_st.ren = ren_in;
    unique case (st_ff.hs)
      grls_pkg::HS_IDLE: begin
        if (tx_valid && st_ff.atn != tx_atn) begin
          // settle attention first so acceptors are armed before dav
          nxt_st.atn = tx_atn;
        end else if (tx_valid && !bus.nrfd && bus.ndac) begin
          nxt_st.hs = grls_pkg::HS_SRC;
          nxt_st.dout = tx_data;
          nxt_st.doe = 1'b1;
          nxt_st.eoi = tx_eoi & ~tx_atn;
          nxt_st.atn = tx_atn;
        end else if (acc_act && bus.dav) begin
          nxt_st.hs = grls_pkg::HS_ACC;
          nxt_st.rxd = bus.dio;
          nxt_st.rxe = bus.eoi;
          nxt_st.rxv = 1'b1;
        end else if (rx_en && !tx_valid) begin
          nxt_st.atn = 1'b0;
        end
      end
      grls_pkg::HS_ACC: begin
        if (!bus.dav) begin
          nxt_st.hs = grls_pkg::HS_IDLE;
        end
      end
      grls_pkg::HS_SRC: begin
        if (!bus.ndac) begin
          nxt_st.hs = grls_pkg::HS_IDLE;
          nxt_st.doe = 1'b0;
          nxt_st.eoi = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.hs <= grls_pkg::HS_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ================================================================
  // outputs
  assign bus.ctl_d_o = st_ff.dout;
  assign bus.ctl_d_oe = st_ff.doe;
  assign bus.ctl_dav_oe = st_ff.hs == grls_pkg::HS_SRC;
  assign bus.ctl_nrfd_oe = acc_act & (st_ff.hs == grls_pkg::HS_ACC);
  assign bus.ctl_ndac_oe = acc_act & (st_ff.hs != grls_pkg::HS_ACC);
  assign bus.ctl_eoi_oe = st_ff.eoi;
  assign bus.ctl_atn_oe = st_ff.atn;
  assign bus.ctl_ren_oe = st_ff.ren;
  assign tx_ready = (st_ff.hs == grls_pkg::HS_SRC) & ~bus.ndac;
  assign rx_data = st_ff.rxd;
  assign rx_eoi = st_ff.rxe;
  assign rx_valid = st_ff.rxv;
  assign srq = bus.srq;

endmodule // grls_ctl

/* grls_defs.svh */
// constants for the instrument-bus remote/local and service-request block
// How it works
// - full source and acceptor handshakes
// - basic talker, serial poll, no talk-only
// - basic listener, no listen-only
// - service request, remote/local, clear, trigger
// - no parallel poll, no controller role
// - panel address 0 to 30, default 2
// - send terminator CR+LF, CR or LF
// - one host interface; instrument bus default
// - REN plus program message enters remote
// - local state until controller takes control
// - GTL when addressed or REN false: local
// - remote, no lockout: local key, and output key when output off
// - remote with lockout: ignore all keys
// - LLO in remote sets; REN false clears
// - output key in remote only when output off; in local it is always taken
// - enabled status summary rising raises request
// - condition edges latch events, enabled summary
// - status bit shows output queue holds data
// - bus cannot change address, terminator, interface
// - request bit 6 set; serial poll clears
// - queue bit 4 follows queue contents
`ifndef GRLS_DEFS_SVH
`define GRLS_DEFS_SVH

// ================================================================
// address and setting defaults
`define GRLS_ADDR_DEF 5'h02
`define GRLS_ADDR_MAX 5'h1e
`define GRLS_IF_DEF 1'b1
`define GRLS_TERM_CRLF 2'h0
`define GRLS_TERM_CR 2'h1
`define GRLS_TERM_LF 2'h2
`define GRLS_TERM_RSVD 2'h3
`define GRLS_TERM_DEF 2'h0
`define GRLS_CHR_CR 8'h0d
`define GRLS_CHR_LF 8'h0a

// ================================================================
// interface messages, seven bits; listen and talk address group bases, two bits
`define GRLS_CMD_GTL 7'h01
`define GRLS_CMD_SDC 7'h04
`define GRLS_CMD_GET 7'h08
`define GRLS_CMD_LLO 7'h11
`define GRLS_CMD_DCL 7'h14
`define GRLS_CMD_SPE 7'h18
`define GRLS_CMD_SPD 7'h19
`define GRLS_CMD_UNL 7'h3f
`define GRLS_CMD_UNT 7'h5f
`define GRLS_LAG_BASE 2'h1
`define GRLS_TAG_BASE 2'h2

// ================================================================
// status byte bit positions
`define GRLS_STB_OSB 7
`define GRLS_STB_RQS 6
`define GRLS_STB_ESB 5
`define GRLS_STB_MAV 4
`define GRLS_STB_EES 1
`define GRLS_STB_EXS 0
`define GRLS_STB_SVC_MASK 8'hbf

`endif

/* grls_dev.sv */
// instrument end: talker, listener, remote/local and service request
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "grls_defs.svh"
module grls_dev #(
  parameter int EW = 8,
  parameter int NK = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  grls_bus_if.dev bus,
  input wire logic [4:0] panel_addr,
  input wire logic panel_addr_wr,
  input wire logic [1:0] panel_term,
  input wire logic panel_term_wr,
  input wire logic panel_if_gpib,
  input wire logic panel_if_wr,
  input wire logic key_local,
  input wire logic key_out,
  input wire logic [NK-1:0] key_other,
  input wire logic output_on,
  output logic remote_indicator_lamp,
  output logic lockout,
  output logic if_gpib,
  output logic [4:0] bus_addr,
  output logic [1:0] term_sel,
  output logic local_key_ok,
  output logic out_key_ok,
  output logic [NK-1:0] other_key_ok,
  output logic [7:0] rx_data,
  output logic rx_eoi,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [EW-1:0] cond,
  input wire logic [EW-1:0] evt_en,
  input wire logic evt_clr,
  output logic [EW-1:0] evt,
  input wire logic [7:0] sre,
  input wire logic osb_sum,
  input wire logic esb_sum,
  input wire logic exs_sum,
  input wire logic queue_nonempty,
  output logic [7:0] stb,
  output logic dev_clear,
  output logic dev_trigger
);

  // ================================================================
  // parameter check
  if (EW < 1 || EW > 32) begin : g_chk_ew
    $error("grls_dev: EW must be 1 to 32");
  end
  if (NK < 1) begin : g_chk_nk
    $error("grls_dev: NK must be at least 1");
  end

  // ================================================================
  // state
  typedef struct packed {
    grls_pkg::grls_rl_t rl;
    logic llo;
    logic lads;
    logic tads;
    logic spms;
    grls_pkg::grls_hs_t hs;
    logic src_data;
    logic src_stb;
    logic [1:0] tph;
    logic [7:0] dout;
    logic doe;
    logic eoi;
    logic [4:0] addr;
    logic [1:0] term;
    logic gpib;
    logic [7:0] rxd;
    logic rxe;
    logic rxv;
    logic clr;
    logic trg;
    logic lok;
    logic ook;
    logic [NK-1:0] kok;
    logic [EW-1:0] cprev;
    logic [EW-1:0] evt;
    logic svc_prev;
    logic rqs;
  } grls_dev_st_t;

  grls_dev_st_t st_ff;
  grls_dev_st_t nxt_st;
  logic acc_act;
  logic talk_ok;
  logic have_byte;
  logic [7:0] sbyte;
  logic seoi;
  logic [7:0] stb_w;
  logic [6:0] cmd;
  logic ees;
  logic svc;

  // ================================================================
  // status byte
  assign ees = |(st_ff.evt & evt_en);
  always_comb begin
    stb_w = 8'h00;
    stb_w[`GRLS_STB_OSB] = osb_sum;
    stb_w[`GRLS_STB_RQS] = st_ff.rqs;
    stb_w[`GRLS_STB_ESB] = esb_sum;
    stb_w[`GRLS_STB_MAV] = queue_nonempty;
    stb_w[`GRLS_STB_EES] = ees;
    stb_w[`GRLS_STB_EXS] = exs_sum;
  end
  assign svc = |(stb_w & sre & `GRLS_STB_SVC_MASK);

  // ================================================================
  // source byte selection
  assign acc_act = st_ff.gpib & (bus.atn | st_ff.lads);
  assign talk_ok = st_ff.gpib & st_ff.tads & ~bus.atn;
  assign have_byte = st_ff.spms | (st_ff.tph != 2'h0) | tx_valid;
  assign cmd = bus.dio[6:0];
  always_comb begin
    sbyte = tx_data;
    seoi = 1'b0;
    if (st_ff.spms) begin
      sbyte = stb_w;
    end else if (st_ff.tph == 2'h1) begin
      sbyte = (st_ff.term == `GRLS_TERM_LF) ? `GRLS_CHR_LF : `GRLS_CHR_CR;
      seoi = st_ff.term != `GRLS_TERM_CRLF;
    end else if (st_ff.tph == 2'h2) begin
      sbyte = `GRLS_CHR_LF;
      seoi = 1'b1;
    end
  end

  // ================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rxv = 1'b0;
    nxt_st.clr = 1'b0;
    nxt_st.trg = 1'b0;
    nxt_st.lok = 1'b0;
    nxt_st.ook = 1'b0;
    nxt_st.kok = '0;
    // settings reachable only from the panel
    if (panel_addr_wr && panel_addr <= `GRLS_ADDR_MAX) begin
      nxt_st.addr = panel_addr;
    end
    if (panel_term_wr && panel_term != `GRLS_TERM_RSVD) begin
      nxt_st.term = panel_term;
    end
    if (panel_if_wr) begin
      nxt_st.gpib = panel_if_gpib;
    end
    unique case (st_ff.hs)
      grls_pkg::HS_IDLE: begin
        if (acc_act && bus.dav) begin
          nxt_st.hs = grls_pkg::HS_ACC;
          if (bus.atn) begin
            if (cmd == {`GRLS_LAG_BASE, st_ff.addr}) begin
              nxt_st.lads = 1'b1;
              nxt_st.tads = 1'b0;
            end else if (cmd == {`GRLS_TAG_BASE, st_ff.addr}) begin
              nxt_st.tads = 1'b1;
              nxt_st.lads = 1'b0;
            end else if (cmd[6:5] == `GRLS_TAG_BASE) begin
              nxt_st.tads = 1'b0;
            end else if (cmd == `GRLS_CMD_UNL) begin
              nxt_st.lads = 1'b0;
            end
            if (cmd == `GRLS_CMD_LLO && st_ff.rl == grls_pkg::RL_REMOTE) begin
              nxt_st.llo = 1'b1;
            end
            if (cmd == `GRLS_CMD_DCL ||
                (cmd == `GRLS_CMD_SDC && st_ff.lads)) begin
              nxt_st.clr = 1'b1;
              nxt_st.tph = 2'h0;
            end
            if (cmd == `GRLS_CMD_GET && st_ff.lads) begin
              nxt_st.trg = 1'b1;
            end
            if (cmd == `GRLS_CMD_GTL && st_ff.lads) begin
              nxt_st.rl = grls_pkg::RL_LOCAL;
            end
            if (cmd == `GRLS_CMD_SPE) begin
              nxt_st.spms = 1'b1;
            end
            if (cmd == `GRLS_CMD_SPD) begin
              nxt_st.spms = 1'b0;
            end
          end else begin
            nxt_st.rxd = bus.dio;
            nxt_st.rxe = bus.eoi;
            nxt_st.rxv = 1'b1;
            if (bus.ren) begin
              nxt_st.rl = grls_pkg::RL_REMOTE;
            end
          end
        end else if (talk_ok && have_byte && !bus.nrfd && bus.ndac) begin
          nxt_st.hs = grls_pkg::HS_SRC;
          nxt_st.dout = sbyte;
          nxt_st.doe = 1'b1;
          nxt_st.eoi = seoi;
          nxt_st.src_stb = st_ff.spms;
          nxt_st.src_data = ~st_ff.spms & (st_ff.tph == 2'h0);
        end
      end
      grls_pkg::HS_ACC: begin
        if (!bus.dav) begin
          nxt_st.hs = grls_pkg::HS_IDLE;
        end
      end
      grls_pkg::HS_SRC: begin
        if (bus.atn || !st_ff.gpib) begin
          nxt_st.hs = grls_pkg::HS_IDLE;
          nxt_st.doe = 1'b0;
          nxt_st.eoi = 1'b0;
        end else if (!bus.ndac) begin
          nxt_st.hs = grls_pkg::HS_IDLE;
          nxt_st.doe = 1'b0;
          nxt_st.eoi = 1'b0;
          if (st_ff.src_stb) begin
            nxt_st.rqs = 1'b0;
          end else if (st_ff.src_data) begin
            nxt_st.tph = tx_last ? 2'h1 : 2'h0;
          end else if (st_ff.tph == 2'h1) begin
            nxt_st.tph = (st_ff.term == `GRLS_TERM_CRLF) ? 2'h2 : 2'h0;
          end else begin
            nxt_st.tph = 2'h0;
          end
        end
      end
    endcase
    if (!bus.ren) begin
      nxt_st.rl = grls_pkg::RL_LOCAL;
      nxt_st.llo = 1'b0;
    end
    // panel keys
    if (st_ff.rl == grls_pkg::RL_LOCAL) begin
      nxt_st.lok = key_local;
      nxt_st.ook = key_out;
      nxt_st.kok = key_other;
    end else if (!st_ff.llo) begin
      if (key_local) begin
        nxt_st.rl = grls_pkg::RL_LOCAL;
        nxt_st.lok = 1'b1;
      end
      nxt_st.ook = key_out & ~output_on;
    end
    // remote with lockout: every key is dropped here
    // events; a new edge wins over a clear
    nxt_st.cprev = cond;
    nxt_st.evt = (st_ff.evt & ~{EW{evt_clr}}) | (cond & ~st_ff.cprev);
    nxt_st.svc_prev = svc;
    if (svc && !st_ff.svc_prev) begin
      nxt_st.rqs = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.rl <= grls_pkg::RL_LOCAL;
      st_ff.hs <= grls_pkg::HS_IDLE;
      st_ff.addr <= `GRLS_ADDR_DEF;
      st_ff.term <= `GRLS_TERM_DEF;
      st_ff.gpib <= `GRLS_IF_DEF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ================================================================
  // outputs; no parallel-poll or controller drive exists
  assign bus.dev_d_o = st_ff.dout;
  assign bus.dev_d_oe = st_ff.doe;
  assign bus.dev_dav_oe = st_ff.hs == grls_pkg::HS_SRC;
  assign bus.dev_nrfd_oe = acc_act & (st_ff.hs == grls_pkg::HS_ACC);
  assign bus.dev_ndac_oe = acc_act & (st_ff.hs != grls_pkg::HS_ACC);
  assign bus.dev_eoi_oe = st_ff.eoi & st_ff.doe;
  assign bus.dev_srq_oe = st_ff.rqs & st_ff.gpib;
  assign tx_ready = (st_ff.hs == grls_pkg::HS_SRC) & st_ff.src_data &
                    ~bus.atn & st_ff.gpib & ~bus.ndac;
  assign remote_indicator_lamp = st_ff.rl == grls_pkg::RL_REMOTE;
  assign lockout = st_ff.llo;
  assign if_gpib = st_ff.gpib;
  assign bus_addr = st_ff.addr;
  assign term_sel = st_ff.term;
  assign local_key_ok = st_ff.lok;
  assign out_key_ok = st_ff.ook;
  assign other_key_ok = st_ff.kok;
  assign rx_data = st_ff.rxd;
  assign rx_eoi = st_ff.rxe;
  assign rx_valid = st_ff.rxv;
  assign evt = st_ff.evt;
  assign stb = stb_w;
  assign dev_clear = st_ff.clr;
  assign dev_trigger = st_ff.trg;

endmodule // grls_dev

/* grls_pkg.sv */
// instrument bus types: handshake states shared by both ends, remote/local state used by the instrument end only
package grls_pkg;

  typedef enum logic [1:0] {
    RL_LOCAL = 2'b01,
    RL_REMOTE = 2'b10
  } grls_rl_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_ACC = 3'b010,
    HS_SRC = 3'b100
  } grls_hs_t;

endpackage
